// file: eipc_defs.svh
/*
 * register offsets, field layouts, reset values and timing counts
 * for the edge interrupt and pulse capture input block.
 * assumes a 40 MHz system clock and a 32-bit register port.
 */
`ifndef EIPC_DEFS_SVH
`define EIPC_DEFS_SVH

`define EIPC_NUM_IN 16
`define EIPC_AW 8

`define EIPC_OFF_CTRL 8'h00
`define EIPC_OFF_FUNC 8'h04
`define EIPC_OFF_COND 8'h08
`define EIPC_OFF_RESP_LO 8'h0C
`define EIPC_OFF_RESP_HI 8'h10
`define EIPC_OFF_STAT 8'h14
`define EIPC_OFF_MASK 8'h18
`define EIPC_OFF_SCAN 8'h1C
`define EIPC_OFF_DEV 8'h20
`define EIPC_OFF_LEVEL 8'h24

`define EIPC_CTRL_EN_BIT 0
`define EIPC_CTRL_RST 1'h0
`define EIPC_FUNC_RST 32'h0000_0000
`define EIPC_COND_RST 32'h0000_0000
`define EIPC_RESP_RST 32'h7777_7777
`define EIPC_MASK_RST 16'h0000

`define EIPC_CLK_NS 25
`define EIPC_TICK_US 10
`define EIPC_TICK_CYC (`EIPC_TICK_US * 1000 / `EIPC_CLK_NS)

`define EIPC_RT0_US 10
`define EIPC_RT1_US 100
`define EIPC_RT2_US 200
`define EIPC_RT3_US 400
`define EIPC_RT4_US 600
`define EIPC_RT5_US 1000
`define EIPC_RT6_US 5000
`define EIPC_RT7_US 10000
`define EIPC_RT8_US 20000
`define EIPC_RT9_US 70000

`endif

// file: eipc_pkg.sv
/*
 * types of the edge interrupt and pulse capture input block.
 * assumes eipc_defs.svh is on the include path.
 */
`include "eipc_defs.svh"

package eipc_pkg;
	typedef enum logic [1:0] {
		EIPC_GENERAL = 2'b00,
		EIPC_INTR = 2'b01,
		EIPC_CAPTURE = 2'b10
	} eipc_func_t;

	typedef enum logic [1:0] {
		EIPC_RISE = 2'b00,
		EIPC_FALL = 2'b01,
		EIPC_BOTH = 2'b10
	} eipc_cond_t;

	typedef struct packed {
		logic [`EIPC_AW-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} eipc_req_t;
endpackage

// file: eipc_inputs.sv
/*
 * sixteen input points: synchroniser, response-time filter, edge
 * interrupt requests and one-scan pulse capture, with register port.
 * assumes the processor writes the scan register at each end of scan
 * and clears status bits when an interrupt routine finishes.
 */
// Our own choices: the address map and the strobed register port.
// Overview of operation
// - interrupt mode, rising condition: each filtered low-to-high edge raises request.
// - interrupt mode, falling condition: each filtered high-to-low edge raises request.
// - interrupt mode, both-edge condition: every rising and falling edge raises a request.
// - one held request per input; further edges while held are dropped.
// - edge during a running routine (bit still set) launches nothing.
// - frequent short pulses raise no more requests than the routine clears; edges while the bit is held are dropped.
// - global allow/block bit and per-routine suppress mask gate interrupts.
// - each point selects function and response time on its own.
// - capture latches pulses shorter than one scan.
// - captured pulse shows on for one scan, cleared at end of scan.
// - only first pulse in a scan is kept; source spaces pulses a scan apart.
// - pulses in successive scans give as many on scans.
// - pulse lasting several scans still shows on for one scan only.
// - on and off widths must exceed the response time to be seen.
// - all sixteen points may be interrupt inputs, request bit per point.
`timescale 1ns/1ps
`include "eipc_defs.svh"

module eipc_filter (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset
	input wire logic pin, // raw field input
	input wire logic tick, // filter time base
	input wire logic [12:0] limit, // response time in ticks
	output logic level // filtered level
);
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic [12:0] cnt;
	logic [12:0] next_cnt;
	logic next_level;

	always_comb
	begin
		next_sync = {sync[1:0], pin};
		next_cnt = cnt;
		next_level = level;
		// a disagreement or a return to the old level restarts the count
		if (sync[2] != sync[1] || sync[2] == level)
			next_cnt = 13'h0000;
		else if (tick)
		begin
			if (cnt + 13'h0001 >= limit)
			begin
				next_level = sync[2];
				next_cnt = 13'h0000;
			end
			else
				next_cnt = cnt + 13'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync <= 3'h0;
			cnt <= 13'h0000;
			level <= 1'b0;
		end
		else
		begin
			sync <= next_sync;
			cnt <= next_cnt;
			level <= next_level;
		end
	end
endmodule

module eipc_inputs #(
	parameter int TICK_CYC = `EIPC_TICK_CYC // cycles per filter tick
)(
	input wire logic clk, // 40 MHz system clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic [`EIPC_NUM_IN-1:0] pin_in, // field inputs
	input wire eipc_pkg::eipc_req_t bus_req, // register request
	output logic [31:0] rdata, // read data, cycle after read
	output logic irq, // interrupt request level
	output logic [`EIPC_NUM_IN-1:0] in_dev // input device image
);
	localparam int N = `EIPC_NUM_IN;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [15:0] tick_cnt;
	logic [15:0] next_tick_cnt;
	logic tick;
	logic next_tick;
	logic ctrl_en;
	logic next_ctrl_en;
	logic [31:0] func;
	logic [31:0] next_func;
	logic [31:0] cond;
	logic [31:0] next_cond;
	logic [63:0] resp;
	logic [63:0] next_resp;
	logic [N-1:0] mask;
	logic [N-1:0] next_mask;
	logic [N-1:0] lvl;
	logic [N-1:0] lvl_q;
	logic [N-1:0] stat;
	logic [N-1:0] next_stat;
	logic [N-1:0] cap_latch;
	logic [N-1:0] next_cap_latch;
	logic [N-1:0] cap_dev;
	logic [N-1:0] next_cap_dev;
	logic [N-1:0] next_in_dev;
	logic [N-1:0] hit;
	logic [N-1:0] cap_hit;
	logic [N-1:0] clr;
	logic [31:0] next_rdata;
	logic next_irq;
	logic wr_hit_stat;
	logic scan_end;
	function automatic logic [12:0] resp_ticks(input logic [3:0] idx);
		case (idx)
			4'h0: resp_ticks = 13'(`EIPC_RT0_US / `EIPC_TICK_US);
			4'h1: resp_ticks = 13'(`EIPC_RT1_US / `EIPC_TICK_US);
			4'h2: resp_ticks = 13'(`EIPC_RT2_US / `EIPC_TICK_US);
			4'h3: resp_ticks = 13'(`EIPC_RT3_US / `EIPC_TICK_US);
			4'h4: resp_ticks = 13'(`EIPC_RT4_US / `EIPC_TICK_US);
			4'h5: resp_ticks = 13'(`EIPC_RT5_US / `EIPC_TICK_US);
			4'h6: resp_ticks = 13'(`EIPC_RT6_US / `EIPC_TICK_US);
			4'h7: resp_ticks = 13'(`EIPC_RT7_US / `EIPC_TICK_US);
			4'h8: resp_ticks = 13'(`EIPC_RT8_US / `EIPC_TICK_US);
			4'h9: resp_ticks = 13'(`EIPC_RT9_US / `EIPC_TICK_US);
			default: resp_ticks = 13'(`EIPC_RT9_US / `EIPC_TICK_US);
		endcase
	endfunction
	// assert asynchronously, release after two edges
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];
	always_comb
	begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 16'h0001;
		if (tick_cnt >= 16'(TICK_CYC - 1))
		begin
			next_tick_cnt = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_pt
			eipc_filter u_flt (
				.clk(clk),
				.rst_n(rst_n),
				.pin(pin_in[gi]),
				.tick(tick),
				.limit(resp_ticks(resp[gi*4 +: 4])),
				.level(lvl[gi])
			);
		end
	endgenerate
	assign wr_hit_stat = bus_req.wr && bus_req.addr == `EIPC_OFF_STAT;
	assign clr = wr_hit_stat ? bus_req.wdata[N-1:0] : '0;
	assign scan_end = bus_req.wr && bus_req.addr == `EIPC_OFF_SCAN;
	// configuration written by software
	always_comb
	begin
		next_ctrl_en = ctrl_en;
		next_func = func;
		next_cond = cond;
		next_resp = resp;
		next_mask = mask;
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				`EIPC_OFF_CTRL: next_ctrl_en = bus_req.wdata[`EIPC_CTRL_EN_BIT];
				`EIPC_OFF_FUNC: next_func = bus_req.wdata;
				`EIPC_OFF_COND: next_cond = bus_req.wdata;
				`EIPC_OFF_RESP_LO: next_resp[31:0] = bus_req.wdata;
				`EIPC_OFF_RESP_HI: next_resp[63:32] = bus_req.wdata;
				`EIPC_OFF_MASK: next_mask = bus_req.wdata[N-1:0];
				default: next_ctrl_en = ctrl_en;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_en <= `EIPC_CTRL_RST;
			func <= `EIPC_FUNC_RST;
			cond <= `EIPC_COND_RST;
			resp <= {`EIPC_RESP_RST, `EIPC_RESP_RST};
			mask <= `EIPC_MASK_RST;
		end
		else
		begin
			ctrl_en <= next_ctrl_en;
			func <= next_func;
			cond <= next_cond;
			resp <= next_resp;
			mask <= next_mask;
		end
	end
	// edge detection, requests, capture and read-back
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			case (eipc_pkg::eipc_cond_t'(cond[i*2 +: 2]))
				eipc_pkg::EIPC_RISE: hit[i] = lvl[i] & ~lvl_q[i];
				eipc_pkg::EIPC_FALL: hit[i] = ~lvl[i] & lvl_q[i];
				eipc_pkg::EIPC_BOTH: hit[i] = lvl[i] ^ lvl_q[i];
				default: hit[i] = 1'b0;
			endcase
			if (func[i*2 +: 2] != eipc_pkg::EIPC_INTR)
				hit[i] = 1'b0;
			cap_hit[i] = lvl[i] & ~lvl_q[i]
				& (func[i*2 +: 2] == eipc_pkg::EIPC_CAPTURE);
			next_in_dev[i] = (func[i*2 +: 2] == eipc_pkg::EIPC_CAPTURE)
				? cap_dev[i] : lvl[i];
		end
		// a set bit absorbs later edges; set wins over a same-cycle clear
		next_stat = (stat & ~clr) | hit;
		// the latch keeps only the first pulse until the scan closes
		next_cap_latch = (scan_end ? '0 : cap_latch) | cap_hit;
		next_cap_dev = scan_end ? cap_latch : cap_dev;
		next_irq = ctrl_en && |(next_stat & ~mask);
		next_rdata = 32'h0000_0000;
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				`EIPC_OFF_CTRL: next_rdata = {31'h0000_0000, ctrl_en};
				`EIPC_OFF_FUNC: next_rdata = func;
				`EIPC_OFF_COND: next_rdata = cond;
				`EIPC_OFF_RESP_LO: next_rdata = resp[31:0];
				`EIPC_OFF_RESP_HI: next_rdata = resp[63:32];
				`EIPC_OFF_STAT: next_rdata = {16'h0000, stat};
				`EIPC_OFF_MASK: next_rdata = {16'h0000, mask};
				`EIPC_OFF_DEV: next_rdata = {16'h0000, in_dev};
				`EIPC_OFF_LEVEL: next_rdata = {16'h0000, lvl};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_q <= '0;
			stat <= '0;
			cap_latch <= '0;
			cap_dev <= '0;
			in_dev <= '0;
			irq <= 1'b0;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			lvl_q <= lvl;
			stat <= next_stat;
			cap_latch <= next_cap_latch;
			cap_dev <= next_cap_dev;
			in_dev <= next_in_dev;
			irq <= next_irq;
			rdata <= next_rdata;
		end
	end

	// point zero carries the interrupt checks, point eight the capture ones
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic f0_int;
	logic f8_cap;
	assign f0_int = func[1:0] == eipc_pkg::EIPC_INTR;
	assign f8_cap = func[17:16] == eipc_pkg::EIPC_CAPTURE;
	sequence s_cap_armed;
		f8_cap && cap_latch[8];
	endsequence
	sequence s_scan_close;
		scan_end;
	endsequence
	rise_request_a: assert property (
		f0_int && cond[1:0] == 2'h0 && lvl[0] && !lvl_q[0] |=> stat[0])
		else $error("rising edge raised no request");
	fall_request_a: assert property (
		f0_int && cond[1:0] == 2'h1 && !lvl[0] && lvl_q[0] |=> stat[0])
		else $error("falling edge raised no request");
	both_request_a: assert property (
		f0_int && cond[1:0] == 2'h2 && (lvl[0] != lvl_q[0]) |=> stat[0])
		else $error("edge in both mode raised no request");
	held_request_a: assert property (
		stat[0] && !clr[0] |=> stat[0])
		else $error("held request lost without a clear");
	request_cause_a: assert property (
		!stat[0] ##1 stat[0] |-> $past(hit[0]))
		else $error("request set without an edge");
	irq_gate_a: assert property (
		irq == ($past(ctrl_en) && |(stat & ~$past(mask))))
		else $error("interrupt output not gated by allow and mask");
	cap_one_scan_a: assert property (
		s_cap_armed ##0 s_scan_close |=> cap_dev[8] ##1 in_dev[8])
		else $error("captured pulse not shown for the next scan");
	cap_scan_hold_a: assert property (
		f8_cap && lvl[8] && lvl_q[8] ##0 s_scan_close |=> !cap_latch[8])
		else $error("held level armed the capture latch again");
	cap_clear_a: assert property (
		s_scan_close ##0 !cap_latch[8] |=> !cap_dev[8])
		else $error("capture image not cleared at end of scan");
endmodule

// file: eipc_field.sv
/*
 * field-side model: sensors and switches driving the sixteen points.
 * assumes the bench calls its tasks and pins change after rising edges.
 */
`timescale 1ns/1ps

module eipc_field (
	input wire logic clk, // system clock
	output logic [15:0] pin_in // field levels
);
	initial pin_in = '0;

	// sources and switches only move pins, never reach the input image
	task automatic drive(input int idx, input logic v);
		@(posedge clk);
		pin_in[idx] <= v;
	endtask

	// on and off widths stay well above the response time
	task automatic pulse(input int idx, input int w);
		drive(idx, 1'b1);
		repeat (w) @(posedge clk);
		drive(idx, 1'b0);
		repeat (w) @(posedge clk);
	endtask
endmodule

// file: testbench.sv
/*
 * self-checking bench for the edge interrupt and pulse capture block.
 * assumes the field model file and the design are compiled before it.
 */
`timescale 1ns/1ps
`include "eipc_defs.svh"

module testbench;
	typedef struct packed {
		logic [3:0] pt;
		logic [1:0] cond;
		logic lv;
		logic ex;
	} eipc_row_t;
	logic clk = 0;
	logic reset_n = 0;
	eipc_pkg::eipc_req_t bus_req = '0;
	logic [15:0] pin_in;
	logic [31:0] rdata;
	logic irq;
	logic [15:0] in_dev;
	logic [31:0] v;
	int error_cnt = 0;
	int comparisons = 0;
	eipc_row_t rows [8] = '{
		'{4'h0, 2'h0, 1'h1, 1'h1}, '{4'h0, 2'h0, 1'h0, 1'h0},
		'{4'h0, 2'h1, 1'h1, 1'h0}, '{4'h0, 2'h1, 1'h0, 1'h1},
		'{4'h2, 2'h2, 1'h1, 1'h1}, '{4'h2, 2'h2, 1'h0, 1'h1},
		'{4'h3, 2'h3, 1'h1, 1'h0}, '{4'h7, 2'h0, 1'h1, 1'h1}};

	always #12.5 clk = ~clk;

	// small tick keeps the 10 us response time at two cycles
	eipc_inputs #(.TICK_CYC(2)) eipc_inputs_i (
		.clk(clk),
		.reset_n(reset_n),
		.pin_in(pin_in),
		.bus_req(bus_req),
		.rdata(rdata),
		.irq(irq),
		.in_dev(in_dev)
	);
	eipc_field eipc_field_i (
		.clk(clk),
		.pin_in(pin_in)
	);

	task automatic finish_test;
		$display("compares %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic wait_lvl(input int i, input logic b);
		logic [31:0] d;
		for (int n = 0; n < 40; n++)
		begin
			rd(`EIPC_OFF_LEVEL, d);
			if (d[i] === b)
				return;
		end
		error_cnt++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, d[i], b);
		finish_test();
	endtask

	task automatic stat_chk(input int i, input logic exp);
		rd(`EIPC_OFF_STAT, v);
		chk(32'(v[i]), 32'(exp));
	endtask

	task automatic scan_chk(input logic exp);
		wr(`EIPC_OFF_SCAN, 32'h0000_0000);
		rd(`EIPC_OFF_DEV, v);
		chk({v[8], in_dev[8]}, {30'h0, exp, exp});
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk({irq, in_dev}, 32'h0000_0000);
		rchk(`EIPC_OFF_CTRL, 32'h0000_0000);
		rchk(`EIPC_OFF_FUNC, `EIPC_FUNC_RST);
		rchk(`EIPC_OFF_COND, `EIPC_COND_RST);
		rchk(`EIPC_OFF_RESP_LO, `EIPC_RESP_RST);
		rchk(`EIPC_OFF_RESP_HI, `EIPC_RESP_RST);
		rchk(`EIPC_OFF_MASK, 32'(`EIPC_MASK_RST));
		rchk(8'h30, 32'h0000_0000);
		$display("reset test done");
		wr(`EIPC_OFF_RESP_LO, 32'h0000_0000);
		wr(`EIPC_OFF_RESP_HI, 32'h0000_0000);
		// points 0-7 interrupt, 8-14 capture, 15 general
		wr(`EIPC_OFF_FUNC, 32'h2AAA_5555);
		wr(`EIPC_OFF_CTRL, 32'h0000_0001);
		foreach (rows[k])
		begin
			wr(`EIPC_OFF_COND, {16{rows[k].cond}});
			eipc_field_i.drive(rows[k].pt, rows[k].lv);
			wait_lvl(rows[k].pt, rows[k].lv);
			stat_chk(rows[k].pt, rows[k].ex);
			chk(32'(irq), 32'(rows[k].ex));
			wr(`EIPC_OFF_STAT, 32'h0000_FFFF);
		end
		$display("edge table test done");
		eipc_field_i.drive(15, 1'b1);
		wait_lvl(15, 1'b1);
		rd(`EIPC_OFF_STAT, v);
		chk({in_dev[15], 15'h0, v[15]}, 32'h0001_0000);
		wr(`EIPC_OFF_COND, 32'h0000_0000);
		wr(`EIPC_OFF_MASK, 32'h0000_0001);
		eipc_field_i.drive(0, 1'b1);
		wait_lvl(0, 1'b1);
		stat_chk(0, 1'b1);
		chk(32'(irq), 32'h0000_0000);
		wr(`EIPC_OFF_MASK, 32'h0000_0000);
		repeat (2) @(negedge clk);
		chk(32'(irq), 32'h0000_0001);
		wr(`EIPC_OFF_CTRL, 32'h0000_0000);
		repeat (2) @(negedge clk);
		chk(32'(irq), 32'h0000_0000);
		wr(`EIPC_OFF_CTRL, 32'h0000_0001);
		wr(`EIPC_OFF_STAT, 32'h0000_FFFF);
		$display("enable and mask test done");
		wr(`EIPC_OFF_COND, 32'hAAAA_AAAA);
		eipc_field_i.drive(0, 1'b0);
		wait_lvl(0, 1'b0);
		eipc_field_i.drive(0, 1'b1);
		wait_lvl(0, 1'b1);
		stat_chk(0, 1'b1);
		wr(`EIPC_OFF_STAT, 32'h0000_0001);
		stat_chk(0, 1'b0);
		wr(`EIPC_OFF_COND, 32'h0000_0000);
		for (int n = 0; n < 3; n++)
		begin
			eipc_field_i.drive(4, 1'b1);
			wait_lvl(4, 1'b1);
			eipc_field_i.drive(4, 1'b0);
			stat_chk(4, 1'b1);
			wr(`EIPC_OFF_STAT, 32'h0000_0010);
			wait_lvl(4, 1'b0);
		end
		$display("held request test done");
		scan_chk(1'b0);
		eipc_field_i.pulse(8, 12);
		rd(`EIPC_OFF_DEV, v);
		chk(32'(v[8]), 32'h0000_0000);
		scan_chk(1'b1);
		scan_chk(1'b0);
		eipc_field_i.pulse(8, 12);
		eipc_field_i.pulse(8, 12);
		scan_chk(1'b1);
		scan_chk(1'b0);
		eipc_field_i.pulse(8, 12);
		scan_chk(1'b1);
		eipc_field_i.pulse(8, 12);
		scan_chk(1'b1);
		scan_chk(1'b0);
		eipc_field_i.drive(8, 1'b1);
		wait_lvl(8, 1'b1);
		scan_chk(1'b1);
		scan_chk(1'b0);
		scan_chk(1'b0);
		eipc_field_i.drive(8, 1'b0);
		wait_lvl(8, 1'b0);
		// point eight at 100 us: twenty cycles with the short tick
		wr(`EIPC_OFF_RESP_HI, 32'h0000_0001);
		eipc_field_i.drive(8, 1'b1);
		repeat (6) @(posedge clk);
		eipc_field_i.drive(8, 1'b0);
		repeat (30) @(posedge clk);
		scan_chk(1'b0);
		eipc_field_i.pulse(8, 40);
		scan_chk(1'b1);
		$display("capture test done");
		wr(`EIPC_OFF_MASK, 32'h0000_FFFF);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk({irq, in_dev}, 32'h0000_0000);
		rchk(`EIPC_OFF_MASK, 32'(`EIPC_MASK_RST));
		rchk(`EIPC_OFF_RESP_HI, `EIPC_RESP_RST);
		rchk(`EIPC_OFF_STAT, 32'h0000_0000);
		$display("second reset test done");
		finish_test();
	end
endmodule
